// *** logic/ebps_pkg.sv ***
package ebps_pkg;
   // ************************************************************
   // Widths
   // ************************************************************
   localparam int NPIN   = 32;
   localparam int NPORT  = 4;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;

   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [4:0] OFF_CTRL   = 5'h00;
   localparam logic [4:0] OFF_HADDR_CTL = 5'h01;
   localparam logic [4:0] OFF_PDATA  = 5'h02;
   localparam logic [4:0] OFF_PDIR   = 5'h06;
   localparam logic [4:0] OFF_PPU    = 5'h0a;
   localparam logic [4:0] OFF_PIN    = 5'h0e;
   localparam logic [4:0] OFF_STATUS = 5'h12;

   // ************************************************************
   // Control fields and reset values
   // ************************************************************
   localparam int CTRL_WR_EN   = 0;
   localparam int CTRL_WR_HI_EN = 1;
   localparam int CTRL_HOLD_EN = 2;
   localparam int CTRL_RDY_EN  = 3;
   localparam int CTRL_CLK_EN  = 4;
   localparam int CTRL_BUS16   = 5;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] HADDR_CTL_RST = 8'h00;
   localparam logic [7:0] PORT_RST = 8'h00;

   // Status fields
   localparam int STAT_MODE   = 0;
   localparam int STAT_EXT    = 3;
   localparam int STAT_BUSCLK = 4;

   // Mode strap code meaning single-chip operation
   localparam logic [2:0] MODE_SINGLE_CHIP = 3'h3;

   // ************************************************************
   // Pin indexes
   // ************************************************************
   localparam int PIN_HADDR = 16;
   localparam int PIN_ALE   = 24;
   localparam int PIN_RD    = 25;
   localparam int PIN_WR_LO    = 26;
   localparam int PIN_WR_HI    = 27;
   localparam int PIN_HOLD_REQ = 28;
   localparam int PIN_HOLD_ACK = 29;
   localparam int PIN_RDY   = 30;
   localparam int PIN_CLK   = 31;

   typedef enum logic [1:0] {ST_SYNC_A, ST_SYNC_B, ST_STRAP, ST_RUN} ebps_state_t;
endpackage

// *** logic/ebps_sync.sv ***
module ebps_sync
   import ebps_pkg::*;
#(
   parameter int W = 1
)
(
   input  wire logic         clk,   // Machine clock
   input  wire logic         nrst,  // Async reset, active low
   input  wire logic [W-1:0] d,     // Asynchronous input
   output logic      [W-1:0] q      // Synchronised output
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_reg <= '0;
         q_reg    <= '0;
      end
      else
      begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;
endmodule // ebps_sync

// *** logic/ebps_pin_cell.sv ***
module ebps_pin_cell
   import ebps_pkg::*;
(
   input  wire logic clk,        // Machine clock
   input  wire logic nrst,       // Async reset, active low
   input  wire logic func_bus,   // Pin owned by the bus
   input  wire logic bus_out,    // Bus output level
   input  wire logic bus_drive,  // Bus drives the pin
   input  wire logic port_out,   // Port output level
   input  wire logic port_drive, // Port direction is output
   input  wire logic pull_en,    // Port pull-up request
   output logic      pin_out,    // Pin output level
   output logic      pin_oe_n,   // Pin driven when low
   output logic      pin_pu      // Pull-up connected
);
   logic out_reg,  out_next;
   logic oe_n_reg, oe_n_next;
   logic pu_reg,   pu_next;

   always_comb
   begin
      if (func_bus)
      begin
         out_next  = bus_out;
         oe_n_next = ~bus_drive;
         pu_next   = 1'b0;
      end
      else
      begin
         out_next  = port_out;
         oe_n_next = ~port_drive;
         // Pull-up only on an undriven port pin, it would fight the driver
         pu_next   = pull_en & ~port_drive;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         out_reg  <= 1'b0;
         oe_n_reg <= 1'b1;
         pu_reg   <= 1'b0;
      end
      else
      begin
         out_reg  <= out_next;
         oe_n_reg <= oe_n_next;
         pu_reg   <= pu_next;
      end
   end

   assign pin_out  = out_reg;
   assign pin_oe_n = oe_n_reg;
   assign pin_pu   = pu_reg;
endmodule // ebps_pin_cell

// *** logic/ebps_pin_select.sv ***
// Operation
// [RULE1] Single-chip: pins are ports, selectable pull-ups
// [RULE2] Bus on: sixteen pins carry address/data
// [RULE3] Upper address driven where control bit 0
// [RULE4] Upper address pin is port where bit 1
// [RULE5] Address latch strobe driven with bus on
// [RULE6] Read strobe driven with bus on
// [RULE7] Low write strobe needs bus and enable
// [RULE8] Low strobe: low byte, or sole strobe
// [RULE9] High strobe needs bus, 16-bit, enable
// [RULE10] Hold request accepted with bus and hold
// [RULE11] Hold acknowledge driven with bus and hold
// [RULE12] Ready sampled with bus and ready enabled
// [RULE13] Bus clock out with bus and clock enable
// [RULE14] Board ties mode straps to fixed levels
// [RULE15] Pin function follows settings next cycle
// [RULE16] Settings keep reset defaults until written
//
// Implementation choices: the plain strobed port and the address map.
module ebps_pin_select
   import ebps_pkg::*;
(
   input  wire logic              clk,           // Machine clock, 250 MHz
   input  wire logic              nrst,          // Async reset, active low
   input  wire logic [ADDR_W-1:0] reg_addr,      // Register address
   input  wire logic [DATA_W-1:0] reg_wdata,     // Register write data
   input  wire logic              reg_wr,        // Write strobe
   input  wire logic              reg_rd,        // Read strobe
   output logic      [DATA_W-1:0] reg_rdata,     // Read data, cycle after rd
   input  wire logic              mode_select_0, // Mode strap 0
   input  wire logic              mode_select_1, // Mode strap 1
   input  wire logic              mode_select_2, // Mode strap 2
   input  wire logic              bus_clk_in,    // Bus clock from timing core
   input  wire logic [23:0]       core_addr,     // Bus address
   input  wire logic [15:0]       core_ad_out,   // Address/data to drive
   input  wire logic              core_ad_drive, // Drive address/data pins
   input  wire logic              core_ale,      // Address latch strobe
   input  wire logic              core_rd_n,     // Read strobe, active low
   input  wire logic              core_wr_lo_n,  // Low write strobe
   input  wire logic              core_wr_hi_n,  // High write strobe
   input  wire logic              core_hold_ack, // Hold acknowledge
   output logic      [15:0]       core_ad_in,    // Sampled address/data
   output logic                   core_hold_req, // Hold request seen
   output logic                   core_rdy,      // External ready
   output logic                   ext_bus_on,    // External bus mode
   output logic                   bus16_on,      // 16-bit bus selected
   input  wire logic [NPIN-1:0]   pin_in,        // Pin input levels
   output logic      [NPIN-1:0]   pin_out,       // Pin output levels
   output logic      [NPIN-1:0]   pin_oe_n,      // Pin driven when low
   output logic      [NPIN-1:0]   pin_pu_en      // Pull-up connected
);
   // ************************************************************
   // Synchronisers
   // ************************************************************
   logic [2:0]      mode_sync;
   logic [NPIN-1:0] pin_sync;
   logic            bclk_sync;

   ebps_sync #(.W(3)) u_mode_sync
   (
      .clk  (clk),
      .nrst (nrst),
      .d    ({mode_select_2, mode_select_1, mode_select_0}),
      .q    (mode_sync)
   );

   ebps_sync #(.W(NPIN)) u_pin_sync
   (
      .clk  (clk),
      .nrst (nrst),
      .d    (pin_in),
      .q    (pin_sync)
   );

   ebps_sync #(.W(1)) u_bclk_sync
   (
      .clk  (clk),
      .nrst (nrst),
      .d    (bus_clk_in),
      .q    (bclk_sync)
   );

   // ************************************************************
   // Mode strap capture
   // ************************************************************
   // Straps are caught once after reset; they must not move later
   ebps_state_t state_reg, state_next;
   logic [2:0]  mode_reg,  mode_next;
   logic        ext_reg,   ext_next;

   always_comb
   begin
      state_next = state_reg;
      mode_next  = mode_reg;
      ext_next   = ext_reg;
      case (state_reg)
         ST_SYNC_A: state_next = ST_SYNC_B;  // Strap synchroniser was reset, let it fill
         ST_SYNC_B: state_next = ST_STRAP;
         ST_STRAP:
         begin
            mode_next  = mode_sync;                      // RULE14
            ext_next   = (mode_sync != MODE_SINGLE_CHIP);
            state_next = ST_RUN;
         end
         ST_RUN: state_next = ST_RUN;
         default: state_next = ST_SYNC_A;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= ST_SYNC_A;
         mode_reg  <= 3'h0;
         ext_reg   <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         mode_reg  <= mode_next;
         ext_reg   <= ext_next;
      end
   end

   // ************************************************************
   // Register file
   // ************************************************************
   logic [7:0]       ctrl_reg,  ctrl_next;
   logic [7:0]       haddr_ctl_reg, haddr_ctl_next;
   logic [3:0][7:0]  pdata_reg, pdata_next;
   logic [3:0][7:0]  pdir_reg,  pdir_next;
   logic [3:0][7:0]  ppu_reg,   ppu_next;
   logic [7:0]       rdata_reg, rdata_next;

   always_comb
   begin
      ctrl_next  = ctrl_reg;
      haddr_ctl_next = haddr_ctl_reg;
      pdata_next = pdata_reg;
      pdir_next  = pdir_reg;
      ppu_next   = ppu_reg;
      rdata_next = 8'h00;
      // Only software writes move a setting
      if (reg_wr)                                         // RULE16
      begin
         for (int p = 0; p < NPORT; p++)
         begin
            if (reg_addr == OFF_PDATA + 5'(p))
               pdata_next[p] = reg_wdata;
            if (reg_addr == OFF_PDIR + 5'(p))
               pdir_next[p] = reg_wdata;
            if (reg_addr == OFF_PPU + 5'(p))
               ppu_next[p] = reg_wdata;                 // RULE1
         end
         if (reg_addr == OFF_CTRL)
            ctrl_next = reg_wdata;
         if (reg_addr == OFF_HADDR_CTL)
            haddr_ctl_next = reg_wdata;
      end
      if (reg_rd)
      begin
         for (int p = 0; p < NPORT; p++)
         begin
            if (reg_addr == OFF_PDATA + 5'(p))
               rdata_next = pdata_reg[p];
            if (reg_addr == OFF_PDIR + 5'(p))
               rdata_next = pdir_reg[p];
            if (reg_addr == OFF_PPU + 5'(p))
               rdata_next = ppu_reg[p];
            if (reg_addr == OFF_PIN + 5'(p))
               rdata_next = pin_sync[p*8 +: 8];
         end
         if (reg_addr == OFF_CTRL)
            rdata_next = ctrl_reg;
         if (reg_addr == OFF_HADDR_CTL)
            rdata_next = haddr_ctl_reg;
         if (reg_addr == OFF_STATUS)
            rdata_next = {3'h0, bclk_sync, ext_reg, mode_reg};
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl_reg  <= CTRL_RST;                           // RULE16
         haddr_ctl_reg <= HADDR_CTL_RST;
         pdata_reg <= {NPORT{PORT_RST}};
         pdir_reg  <= {NPORT{PORT_RST}};
         ppu_reg   <= {NPORT{PORT_RST}};
         rdata_reg <= 8'h00;
      end
      else
      begin
         ctrl_reg  <= ctrl_next;
         haddr_ctl_reg <= haddr_ctl_next;
         pdata_reg <= pdata_next;
         pdir_reg  <= pdir_next;
         ppu_reg   <= ppu_next;
         rdata_reg <= rdata_next;
      end
   end

   // ************************************************************
   // Pin function selection
   // ************************************************************
   logic            wr_on, wr_hi_on, hold_on, rdy_on, clk_on, b16;
   logic [NPIN-1:0] fsel, bout, bdrv;

   assign b16     = ctrl_reg[CTRL_BUS16];
   assign wr_on   = ext_reg & ctrl_reg[CTRL_WR_EN];
   assign wr_hi_on = ext_reg & b16 & ctrl_reg[CTRL_WR_HI_EN];
   assign hold_on = ext_reg & ctrl_reg[CTRL_HOLD_EN];
   assign rdy_on  = ext_reg & ctrl_reg[CTRL_RDY_EN];
   assign clk_on  = ext_reg & ctrl_reg[CTRL_CLK_EN];

   // Pure decode of settings; the pin cells register it once
   always_comb                                             // RULE15
   begin
      fsel = '0;
      bout = '0;
      bdrv = '0;
      for (int i = 0; i < 16; i++)
      begin
         fsel[i] = ext_reg;                                // RULE2
         bout[i] = core_ad_out[i];
         bdrv[i] = core_ad_drive;
      end
      for (int i = 0; i < 8; i++)
      begin
         fsel[PIN_HADDR+i] = ext_reg & ~haddr_ctl_reg[i];   // RULE3 RULE4
         bout[PIN_HADDR+i] = core_addr[16+i];
         bdrv[PIN_HADDR+i] = 1'b1;
      end
      fsel[PIN_ALE] = ext_reg;                             // RULE5
      bout[PIN_ALE] = core_ale;
      bdrv[PIN_ALE] = 1'b1;
      fsel[PIN_RD]  = ext_reg;                             // RULE6
      bout[PIN_RD]  = core_rd_n;
      bdrv[PIN_RD]  = 1'b1;
      // Same pin is the only write strobe on an 8-bit bus
      fsel[PIN_WR_LO] = wr_on;                             // RULE7 RULE8
      bout[PIN_WR_LO] = core_wr_lo_n;
      bdrv[PIN_WR_LO] = 1'b1;
      fsel[PIN_WR_HI] = wr_hi_on;                          // RULE9
      bout[PIN_WR_HI] = core_wr_hi_n;
      bdrv[PIN_WR_HI] = 1'b1;
      fsel[PIN_HOLD_REQ] = hold_on;                        // RULE10
      fsel[PIN_HOLD_ACK] = hold_on;                        // RULE11
      bout[PIN_HOLD_ACK] = core_hold_ack;
      bdrv[PIN_HOLD_ACK] = 1'b1;
      fsel[PIN_RDY] = rdy_on;                              // RULE12
      fsel[PIN_CLK] = clk_on;                              // RULE13
      bout[PIN_CLK] = bclk_sync;
      bdrv[PIN_CLK] = 1'b1;
   end

   genvar g;
   generate
      for (g = 0; g < NPIN; g++)
      begin : g_pin
         ebps_pin_cell u_cell
         (
            .clk        (clk),
            .nrst       (nrst),
            .func_bus   (fsel[g]),
            .bus_out    (bout[g]),
            .bus_drive  (bdrv[g]),
            .port_out   (pdata_reg[g/8][g%8]),
            .port_drive (pdir_reg[g/8][g%8]),
            .pull_en    (ppu_reg[g/8][g%8]),
            .pin_out    (pin_out[g]),
            .pin_oe_n   (pin_oe_n[g]),
            .pin_pu     (pin_pu_en[g])
         );
      end
   endgenerate

   // ************************************************************
   // Inputs back to the bus core
   // ************************************************************
   logic [15:0] adin_reg;
   logic        hreq_reg, hreq_next;
   logic        rdy_reg, rdy_next;
   logic        ext_o_reg, b16_reg;

   always_comb
   begin
      hreq_next = hold_on & pin_sync[PIN_HOLD_REQ];        // RULE10
      // Without the ready function every cycle counts as ready
      rdy_next = rdy_on ? pin_sync[PIN_RDY] : 1'b1;        // RULE12
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         adin_reg  <= 16'h0000;
         hreq_reg  <= 1'b0;
         rdy_reg   <= 1'b1;
         ext_o_reg <= 1'b0;
         b16_reg   <= 1'b0;
      end
      else
      begin
         adin_reg  <= pin_sync[15:0];
         hreq_reg  <= hreq_next;
         rdy_reg   <= rdy_next;
         ext_o_reg <= ext_reg;
         b16_reg   <= b16;
      end
   end

   assign reg_rdata  = rdata_reg;
   assign core_ad_in = adin_reg;
   assign core_hold_req = hreq_reg;
   assign core_rdy   = rdy_reg;
   assign ext_bus_on = ext_o_reg;
   assign bus16_on   = b16_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   ad_bus_drive_a: assert property (@(posedge clk) disable iff (!nrst) // RULE2
      (ext_reg && core_ad_drive) |=>
      (pin_oe_n[15:0] == 16'h0000 && pin_out[15:0] == $past(core_ad_out)))
      else $error("address/data pins not driven");
   haddr_drive_a: assert property (@(posedge clk) disable iff (!nrst) // RULE3
      (ext_reg && !haddr_ctl_reg[0]) |=>
      (!pin_oe_n[PIN_HADDR] && pin_out[PIN_HADDR] == $past(core_addr[16])))
      else $error("upper address not driven");
   haddr_port_a: assert property (@(posedge clk) disable iff (!nrst) // RULE4
      (ext_reg && haddr_ctl_reg[7] && !pdir_reg[2][7]) |=> pin_oe_n[PIN_HADDR+7])
      else $error("released upper address pin driven");
   ale_out_a: assert property (@(posedge clk) disable iff (!nrst) // RULE5
      ext_reg |=> (!pin_oe_n[PIN_ALE] && pin_out[PIN_ALE] == $past(core_ale)))
      else $error("latch strobe missing");
   rd_strobe_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
      ext_reg |=> (pin_out[PIN_RD] == $past(core_rd_n)))
      else $error("read strobe wrong");
   wr_lo_gate_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
      (!wr_on && !pdir_reg[3][2]) |=> pin_oe_n[PIN_WR_LO])
      else $error("low write strobe driven while off");
   wr_hi_gate_a: assert property (@(posedge clk) disable iff (!nrst) // RULE9
      (ext_reg && !b16 && !pdir_reg[3][3]) |=> pin_oe_n[PIN_WR_HI])
      else $error("high write strobe on 8-bit bus");
   hold_req_a: assert property (@(posedge clk) disable iff (!nrst) // RULE10
      !hold_on |=> !core_hold_req)
      else $error("hold request accepted while off");
   rdy_sample_a: assert property (@(posedge clk) disable iff (!nrst) // RULE12
      rdy_on |=> (core_rdy == $past(pin_sync[PIN_RDY])))
      else $error("ready not sampled");
   clk_out_a: assert property (@(posedge clk) disable iff (!nrst) // RULE13
      clk_on |=> (!pin_oe_n[PIN_CLK] && pin_out[PIN_CLK] == $past(bclk_sync)))
      else $error("bus clock not output");
   port_mode_a: assert property (@(posedge clk) disable iff (!nrst) // RULE1
      (!ext_reg && pdir_reg[0][0]) |=>
      (!pin_oe_n[0] && pin_out[0] == $past(pdata_reg[0][0])))
      else $error("single-chip port pin wrong");
   ctrl_hold_a: assert property (@(posedge clk) disable iff (!nrst) // RULE16
      !reg_wr |=> ($stable(ctrl_reg) && $stable(haddr_ctl_reg)))
      else $error("setting changed without a write");

   ext_drive_c: cover property (@(posedge clk) disable iff (!nrst)
      ext_reg && core_ad_drive);
   haddr_port_c: cover property (@(posedge clk) disable iff (!nrst)
      ext_reg && haddr_ctl_reg != 8'h00);
   hold_c: cover property (@(posedge clk) disable iff (!nrst) hold_on && core_hold_req);
   wr_hi_c: cover property (@(posedge clk) disable iff (!nrst) wr_hi_on);
endmodule // ebps_pin_select

// *** test/ebps_bus_partner.sv ***
module ebps_bus_partner
   import ebps_pkg::*;
(
   input  wire logic            clk,       // Machine clock
   input  wire logic [NPIN-1:0] pin_out,   // Device output levels
   input  wire logic [NPIN-1:0] pin_oe_n,  // Device drives when low
   input  wire logic [NPIN-1:0] pin_pu_en, // Device pull-ups
   input  wire logic            hold_req,  // External master wants the bus
   input  wire logic            ready_lvl, // Slow device ready level
   input  wire logic [15:0]     rd_word,   // Word returned on reads
   output logic      [NPIN-1:0] pin_in     // Resolved wire levels
);
   timeunit 1ns;
   timeprecision 1ps;
   logic churn_reg = 1'b0;
   logic rd_active;

   // Floating lines toggle so a stale value can never pass for a driven one
   always @(posedge clk)
      churn_reg <= ~churn_reg;

   assign rd_active = !pin_oe_n[PIN_RD] && !pin_out[PIN_RD];

   always_comb
   begin
      for (int i = 0; i < NPIN; i++)
      begin
         if (!pin_oe_n[i])
            pin_in[i] = pin_out[i];
         else if (i < 16 && rd_active)
            pin_in[i] = rd_word[i];
         else if (i == PIN_HOLD_REQ)
            pin_in[i] = hold_req;
         else if (i == PIN_RDY)
            pin_in[i] = ready_lvl;
         else if (pin_pu_en[i])
            pin_in[i] = 1'b1;
         else
            pin_in[i] = churn_reg ^ i[0];
      end
   end
endmodule // ebps_bus_partner

// *** test/tb_top.sv ***
module tb_top
   import ebps_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, nrst, reg_wr, reg_rd, bus_clk_in, core_hold_ack;
   logic [2:0]        bclk_hist;
   logic [ADDR_W-1:0] reg_addr;
   logic [7:0]        reg_wdata, reg_rdata;
   logic              mode_select_0, mode_select_1, mode_select_2;
   logic [23:0]       core_addr;
   logic [15:0]       core_ad_out, core_ad_in, rd_word;
   logic              core_ad_drive, core_ale, core_rd_n, core_wr_lo_n, core_wr_hi_n;
   logic              core_hold_req, core_rdy, ext_bus_on, bus16_on, hold_req, ready_lvl;
   logic [31:0]       pin_in, pin_out, pin_oe_n, pin_pu_en;
   logic [4:0]        base [3] = '{OFF_PDATA, OFF_PDIR, OFF_PPU};
   int                n_errors, tests_run, cycles, seed, ctrl_m, haddr_m;
   int                preg [3][4];
   bit                ext_m;

   ebps_pin_select uut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .mode_select_0, .mode_select_1, .mode_select_2, .bus_clk_in, .core_addr, .core_ad_out,
      .core_ad_drive, .core_ale, .core_rd_n, .core_wr_lo_n, .core_wr_hi_n, .core_hold_ack, .core_ad_in,
      .core_hold_req, .core_rdy, .ext_bus_on, .bus16_on, .pin_in, .pin_out, .pin_oe_n, .pin_pu_en);
   ebps_bus_partner partner (.clk, .pin_out, .pin_oe_n, .pin_pu_en, .hold_req, .ready_lvl,
      .rd_word, .pin_in);

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Unrelated phase to the machine clock on purpose
   initial
   begin
      bus_clk_in = 1'b0;
      #3;
      forever #16 bus_clk_in = ~bus_clk_in;
   end

   always @(posedge clk)
   begin
      cycles++;
      bclk_hist <= {bclk_hist[1:0], bus_clk_in};
      if (cycles == 20000)
      begin
         n_errors++;
         $display("[FAIL] run length expected done seen hang");
         test_done();
      end
   end

   // ******************************************************
   // Tasks
   // ******************************************************
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic reg_wr_t(input logic [4:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_rd_t(input logic [4:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   task automatic rd_chk(input string what, input logic [4:0] a, input logic [7:0] e);
      logic [7:0] d;
      reg_rd_t(a, d);
      // Status shows the bus clock level from two edges before the read was taken
      if (a == OFF_STATUS)
         e[STAT_BUSCLK] = bclk_hist[2];
      chk(what, e, d);
      @(posedge clk);
      #1 chk("rdata idle", 0, reg_rdata);
   endtask

   task automatic do_reset(input logic [2:0] strap);
      nrst <= 1'b0;
      {mode_select_2, mode_select_1, mode_select_0} <= strap;
      repeat (6) @(posedge clk);
      chk("oe_n in reset", 32'hffffffff, pin_oe_n);
      chk("pu in reset", 0, pin_pu_en);
      chk("rdy in reset", 1, core_rdy);
      nrst <= 1'b1;
      ext_m = (strap != MODE_SINGLE_CHIP);
      ctrl_m = 0;
      haddr_m = 0;
      preg = '{default: 0};
      repeat (3) @(posedge clk);
      rd_chk("ctrl", OFF_CTRL, 0);
      rd_chk("haddr ctl", OFF_HADDR_CTL, 0);
      for (int k = 0; k < 12; k++)
         rd_chk("port reg", 5'(base[k/4] + k%4), 0);
      rd_chk("status", OFF_STATUS, {4'h0, ext_m, strap});
   endtask

   task automatic stir(input int c);
      ctrl_m = c;
      haddr_m = $random(seed) & 255;
      reg_wr_t(OFF_CTRL, 8'(c));
      reg_wr_t(OFF_HADDR_CTL, 8'(haddr_m));
      for (int k = 0; k < 12; k++)
      begin
         preg[k/4][k%4] = $random(seed) & 255;
         reg_wr_t(5'(base[k/4] + k%4), 8'(preg[k/4][k%4]));
      end
      rd_chk("ctrl", OFF_CTRL, 8'(c));
      rd_chk("haddr ctl", OFF_HADDR_CTL, 8'(haddr_m));
      @(posedge clk);
      {core_ad_drive, core_ale, core_rd_n, core_wr_lo_n, core_wr_hi_n, core_hold_ack, hold_req,
         ready_lvl} <= 8'($random(seed));
      core_addr   <= 24'($random(seed));
      core_ad_out <= 16'($random(seed));
      rd_word     <= 16'($random(seed));
   endtask

   task automatic check_pins();
      logic [31:0] own, drv, val, pu, msk, bv, ad;
      logic [7:0]  d;
      repeat (6) @(posedge clk);
      #1;
      bv = {2'b00, core_hold_ack, 1'b0, core_wr_hi_n, core_wr_lo_n, core_rd_n, core_ale,
            core_addr[23:16], core_ad_out};
      for (int i = 0; i < 32; i++)
      begin
         own[i] = ext_m && (i < 16 || (i < 24 && !haddr_m[i-16]) || i == 24 || i == 25 ||
                  (i == 26 && ctrl_m[0]) || (i == 27 && ctrl_m[5] && ctrl_m[1]) ||
                  ((i == 28 || i == 29) && ctrl_m[2]) || (i == 30 && ctrl_m[3]) ||
                  (i == 31 && ctrl_m[4]));
         drv[i] = own[i] ? (i < 16 ? core_ad_drive : (i != 28 && i != 30)) : preg[1][i/8][i%8];
         val[i] = own[i] ? bv[i] : preg[0][i/8][i%8];
         pu[i]  = !own[i] && preg[2][i/8][i%8] && !preg[1][i/8][i%8];
      end
      msk = drv & ~{own[31], 31'h0};
      ad  = (drv & val) | (~drv & {16'h0, rd_word});
      chk("pin_oe_n", ~drv, pin_oe_n);
      chk("pin_out", val & msk, pin_out & msk);
      chk("pin_pu_en", pu, pin_pu_en);
      chk("ext_bus_on", ext_m, ext_bus_on);
      chk("bus16_on", ctrl_m[5], bus16_on);
      chk("core_hold_req", own[28] & hold_req, core_hold_req);
      chk("core_rdy", !own[30] | ready_lvl, core_rdy);
      if (drv[25] && !val[25])
         chk("core_ad_in", ad & 32'hffff, core_ad_in);
      for (int p = 0; p < 4 && !ext_m; p++)
      begin
         reg_rd_t(5'(OFF_PIN + p), d);
         chk("pin read", 0, (d ^ preg[0][p]) & preg[1][p]);
      end
   endtask

   // ******************************************************
   // Main sequence
   // ******************************************************
   initial
   begin
      seed = 93;
      {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
      {mode_select_2, mode_select_1, mode_select_0} = MODE_SINGLE_CHIP;
      {core_addr, core_ad_out, core_ad_drive, core_ale, core_hold_ack} = '0;
      {core_rd_n, core_wr_lo_n, core_wr_hi_n, hold_req, ready_lvl, rd_word} = '1;
      do_reset(MODE_SINGLE_CHIP);
      for (int k = 0; k < 16; k++)
      begin
         stir($random(seed) & 63);
         check_pins();
      end
      rd_chk("unmapped read", 5'h1f, 0);
      reg_wr_t(5'h1f, 8'hff);
      rd_chk("ctrl after stray write", OFF_CTRL, 8'(ctrl_m));
      do_reset(3'h6);
      // Every combination of the six control bits in bus mode
      for (int c = 0; c < 64; c++)
      begin
         stir(c);
         check_pins();
      end
      reg_wr_t(OFF_CTRL, 8'h2f);
      #1 chk("clk pin old", 0, pin_oe_n[31]);
      @(posedge clk);
      #1 chk("clk pin new", !preg[1][3][7], pin_oe_n[31]);
      ctrl_m = 'h2f;
      check_pins();
      test_done();
   end
endmodule // tb_top
